// file: rtl/cwpr_regs.sv
// Functional notes
// - Window top Y kept as 13 bits
// - Window settings ignored in linear mode
// - Window width kept as 14 bits
// - Window height kept as 14 bits
// - Bit 3 picks write or prefetch readback
// - Bit 2 picks block or linear addressing
// - Block mode depth: 8, 16, 24 bpp
// - Linear mode: bit 0 picks 8/16-bit transfers
// - Linear mode: X register is address 15..0
// - Linear mode: Y register is address 31..16
// - Block mode: positions are 13-bit coordinates
// - Position write sets, read returns position
// - Text write X kept, written and read
`timescale 1ns/100ps
`default_nettype none
module cwpr_regs (
  input  wire logic             clk_sys,       // Core clock
  input  wire logic             rst_n,         // Synchronous reset, low
  input  wire logic [7:0]       addr,          // Register byte address
  input  wire logic [7:0]       wdata,         // Write data
  input  wire logic             wr_stb,        // Write strobe
  input  wire logic             rd_stb,        // Read strobe
  output logic      [7:0]       rdata,         // Read data, next cycle
  input  wire logic             eng_wpos_load, // Engine moves write position
  input  wire logic [15:0]      eng_wpos_x,    // New write position X
  input  wire logic [15:0]      eng_wpos_y,    // New write position Y
  input  wire logic             eng_rpos_load, // Engine moves prefetch pos
  input  wire logic [15:0]      eng_rpos_x,    // New prefetch position X
  input  wire logic [15:0]      eng_rpos_y,    // New prefetch position Y
  input  wire logic             eng_text_load, // Engine moves text position
  input  wire logic [12:0]      eng_text_x,    // New text position X
  output logic                  win_enable,    // Window settings in force
  output logic      [12:0]      win_top_y,     // Window top Y, pixels
  output logic      [13:0]      win_width,     // Window width, pixels
  output logic      [13:0]      win_height,    // Window height, pixels
  output logic                  linear_mode,   // Linear byte addressing
  output cwpr_pkg::cwpr_bpp_t   pixel_depth,   // Block mode colour depth
  output logic                  mem_wide,      // Linear 16-bit transfers
  output logic      [12:0]      wr_coord_x,    // Block write X coordinate
  output logic      [12:0]      wr_coord_y,    // Block write Y coordinate
  output logic      [31:0]      wr_lin_addr,   // Linear write byte address
  output logic      [12:0]      rd_coord_x,    // Block prefetch X
  output logic      [12:0]      rd_coord_y,    // Block prefetch Y
  output logic      [31:0]      rd_lin_addr,   // Linear prefetch address
  output logic      [12:0]      text_x         // Text write X position
);
  import cwpr_pkg::*;

  // Merge a host byte write into a register pair and drop unused bits
  function automatic logic [15:0] put_byte(
    input logic [15:0] cur,
    input logic        lo_hit,
    input logic        hi_hit,
    input logic [7:0]  d,
    input logic [15:0] mask
  );
    logic [15:0] v;
    v = cur;
    if (lo_hit) begin
      v[7:0] = d;
    end
    if (hi_hit) begin
      v[15:8] = d;
    end
    // Unused bits never reach the flops
    put_byte = v & mask;
  endfunction : put_byte

  // Pick the low or high byte of a pair
  function automatic logic [7:0] get_byte(
    input logic [15:0] w,
    input logic        hi
  );
    get_byte = hi ? w[15:8] : w[7:0];
  endfunction : get_byte

  // Block coordinate of a pair, forced to zero in linear mode
  function automatic logic [12:0] blk_coord(
    input logic        lin_on,
    input logic [15:0] w
  );
    blk_coord = lin_on ? 13'h0000 : w[12:0];
  endfunction : blk_coord

  // Window size of a pair, forced to zero in linear mode
  function automatic logic [13:0] blk_size(
    input logic        lin_on,
    input logic [15:0] w
  );
    blk_size = lin_on ? 14'h0000 : w[13:0];
  endfunction : blk_size

  // Byte address from a Y and X pair, zero in block mode
  // Y gives bits 31..16, X bits 15..0
  function automatic logic [31:0] lin_addr(
    input logic        lin_on,
    input logic [15:0] hi_w,
    input logic [15:0] lo_w
  );
    lin_addr = lin_on ? {hi_w, lo_w} : 32'h0000_0000;
  endfunction : lin_addr

  // Colour depth from the two depth bits
  // Bit 1 set gives 24 bpp whatever bit 0 holds
  function automatic cwpr_bpp_t bpp_of(
    input logic d1,
    input logic d0
  );
    bpp_of = d1 ? CWPR_BPP24 : (d0 ? CWPR_BPP16 : CWPR_BPP8);
  endfunction : bpp_of

  // Stored state
  logic [15:0] topy_reg;   // Window top Y
  logic [15:0] wid_reg;    // Window width
  logic [15:0] hgt_reg;    // Window height
  logic [7:0]  mode_reg;   // Depth, mode, readback select
  logic [15:0] gwx_reg;    // Graphic write position X
  logic [15:0] gwy_reg;    // Graphic write position Y
  logic [15:0] grx_reg;    // Graphic prefetch position X
  logic [15:0] gry_reg;    // Graphic prefetch position Y
  logic [15:0] txt_reg;    // Text write X
  logic [7:0]  rdata_reg;  // Registered read data

  // Next values
  logic [15:0] topy_next;  // Window top Y next
  logic [15:0] wid_next;   // Window width next
  logic [15:0] hgt_next;   // Window height next
  logic [7:0]  mode_next;  // Mode next
  logic [15:0] gwx_next;   // Write X next
  logic [15:0] gwy_next;   // Write Y next
  logic [15:0] grx_next;   // Prefetch X next
  logic [15:0] gry_next;   // Prefetch Y next
  logic [15:0] txt_next;   // Text X next
  logic [7:0]  rdata_next; // Read data next

  // Output flops
  logic        win_en_reg; // Window in force
  logic [12:0] win_y_reg;  // Window top Y out
  logic [13:0] win_w_reg;  // Window width out
  logic [13:0] win_h_reg;  // Window height out
  logic        lin_reg;    // Linear mode out
  cwpr_bpp_t   depth_reg;  // Colour depth out
  logic        wide_reg;   // 16-bit transfers out
  logic [12:0] wcx_reg;    // Write X coordinate out
  logic [12:0] wcy_reg;    // Write Y coordinate out
  logic [31:0] wla_reg;    // Write byte address out
  logic [12:0] rcx_reg;    // Prefetch X out
  logic [12:0] rcy_reg;    // Prefetch Y out
  logic [31:0] rla_reg;    // Prefetch byte address out
  logic [12:0] txtx_reg;   // Text X out

  // Address decode for writes
  wire w_topy_lo = wr_stb && (addr == CWPR_OFF_TOPY_LO); // Top Y low
  wire w_topy_hi = wr_stb && (addr == CWPR_OFF_TOPY_HI); // Top Y high
  wire w_wid_lo  = wr_stb && (addr == CWPR_OFF_WID_LO);  // Width low
  wire w_wid_hi  = wr_stb && (addr == CWPR_OFF_WID_HI);  // Width high
  wire w_hgt_lo  = wr_stb && (addr == CWPR_OFF_HGT_LO);  // Height low
  wire w_hgt_hi  = wr_stb && (addr == CWPR_OFF_HGT_HI);  // Height high
  wire w_mode    = wr_stb && (addr == CWPR_OFF_MODE);    // Mode
  wire w_gpx_lo  = wr_stb && (addr == CWPR_OFF_GPX_LO);  // Position X low
  wire w_gpx_hi  = wr_stb && (addr == CWPR_OFF_GPX_HI);  // Position X high
  wire w_gpy_lo  = wr_stb && (addr == CWPR_OFF_GPY_LO);  // Position Y low
  wire w_gpy_hi  = wr_stb && (addr == CWPR_OFF_GPY_HI);  // Position Y high
  wire w_txt_lo  = wr_stb && (addr == CWPR_OFF_TXT_LO);  // Text X low
  wire w_txt_hi  = wr_stb && (addr == CWPR_OFF_TXT_HI);  // Text X high

  // Mode bit decode
  wire rd_sel  = mode_reg[CWPR_BIT_RDSEL];  // Readback prefetch position
  wire lin     = mode_reg[CWPR_BIT_LINEAR]; // Linear addressing

  // Window geometry, stored with unused high bits dropped
  assign topy_next = put_byte(topy_reg, w_topy_lo, w_topy_hi, wdata,
                              CWPR_MASK_COORD);
  assign wid_next  = put_byte(wid_reg, w_wid_lo, w_wid_hi, wdata,
                              CWPR_MASK_SIZE);
  assign hgt_next  = put_byte(hgt_reg, w_hgt_lo, w_hgt_hi, wdata,
                              CWPR_MASK_SIZE);

  // Mode register keeps bits 3..0, upper bits read zero
  assign mode_next = w_mode ? (wdata & CWPR_MASK_MODE) : mode_reg;

  // Engine updates first, so a host write in the same cycle wins
  wire [15:0] gwx_base = eng_wpos_load ? eng_wpos_x : gwx_reg; // Write X
  wire [15:0] gwy_base = eng_wpos_load ? eng_wpos_y : gwy_reg; // Write Y
  wire [15:0] grx_base = eng_rpos_load ? eng_rpos_x : grx_reg; // Prefetch X
  wire [15:0] gry_base = eng_rpos_load ? eng_rpos_y : gry_reg; // Prefetch Y
  wire [15:0] txt_base = eng_text_load ? {3'h0, eng_text_x} : txt_reg;

  // A host position write sets both write and prefetch positions
  assign gwx_next = put_byte(gwx_base, w_gpx_lo, w_gpx_hi, wdata,
                             CWPR_MASK_POS);
  assign gwy_next = put_byte(gwy_base, w_gpy_lo, w_gpy_hi, wdata,
                             CWPR_MASK_POS);
  assign grx_next = put_byte(grx_base, w_gpx_lo, w_gpx_hi, wdata,
                             CWPR_MASK_POS);
  assign gry_next = put_byte(gry_base, w_gpy_lo, w_gpy_hi, wdata,
                             CWPR_MASK_POS);
  assign txt_next = put_byte(txt_base, w_txt_lo, w_txt_hi, wdata,
                             CWPR_MASK_COORD);

  // Position seen by readback: write or prefetch
  wire [15:0] view_x = rd_sel ? grx_reg : gwx_reg;
  wire [15:0] view_y = rd_sel ? gry_reg : gwy_reg;

  // Block mode shows 13-bit coordinates, linear mode the full address
  wire [15:0] pos_mask = lin ? CWPR_MASK_POS : CWPR_MASK_COORD;
  wire [15:0] rb_x     = view_x & pos_mask; // Readback X
  wire [15:0] rb_y     = view_y & pos_mask; // Readback Y

  // Read data selection; unmapped addresses read zero
  assign rdata_next =
    !rd_stb                   ? 8'h00 :
    (addr == CWPR_OFF_TOPY_LO) ? get_byte(topy_reg, 1'b0) :
    (addr == CWPR_OFF_TOPY_HI) ? get_byte(topy_reg, 1'b1) :
    (addr == CWPR_OFF_WID_LO)  ? get_byte(wid_reg, 1'b0)  :
    (addr == CWPR_OFF_WID_HI)  ? get_byte(wid_reg, 1'b1)  :
    (addr == CWPR_OFF_HGT_LO)  ? get_byte(hgt_reg, 1'b0)  :
    (addr == CWPR_OFF_HGT_HI)  ? get_byte(hgt_reg, 1'b1)  :
    (addr == CWPR_OFF_MODE)    ? mode_reg                 :
    (addr == CWPR_OFF_GPX_LO)  ? get_byte(rb_x, 1'b0)     :
    (addr == CWPR_OFF_GPX_HI)  ? get_byte(rb_x, 1'b1)     :
    (addr == CWPR_OFF_GPY_LO)  ? get_byte(rb_y, 1'b0)     :
    (addr == CWPR_OFF_GPY_HI)  ? get_byte(rb_y, 1'b1)     :
    (addr == CWPR_OFF_TXT_LO)  ? get_byte(txt_reg, 1'b0)  :
    (addr == CWPR_OFF_TXT_HI)  ? get_byte(txt_reg, 1'b1)  :
    8'h00;

  // Geometry and mode registers, cleared by reset
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      topy_reg <= CWPR_RST_WORD;
      wid_reg  <= CWPR_RST_WORD;
      hgt_reg  <= CWPR_RST_WORD;
      mode_reg <= CWPR_RST_MODE;
    end else begin
      topy_reg <= topy_next;
      wid_reg  <= wid_next;
      hgt_reg  <= hgt_next;
      mode_reg <= mode_next;
    end
  end

  // Position registers, cleared by reset
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      gwx_reg <= CWPR_RST_WORD;
      gwy_reg <= CWPR_RST_WORD;
      grx_reg <= CWPR_RST_WORD;
      gry_reg <= CWPR_RST_WORD;
      txt_reg <= CWPR_RST_WORD;
    end else begin
      gwx_reg <= gwx_next;
      gwy_reg <= gwy_next;
      grx_reg <= grx_next;
      gry_reg <= gry_next;
      txt_reg <= txt_next;
    end
  end

  // Read data register, valid only in the cycle after the strobe
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // Read data port
  assign rdata = rdata_reg;

  // Mode fields as they will stand once this edge has passed
  wire lin_nx    = mode_next[CWPR_BIT_LINEAR]; // Next addressing mode
  wire dep_hi_nx = mode_next[CWPR_BIT_DEPTH1]; // Next depth upper bit
  wire dep_lo_nx = mode_next[CWPR_BIT_DEPTH0]; // Next depth lower bit

  // Window and mode outputs, loaded from next values so that they move
  // at the same edge as the registers they decode
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      // Reset state is block mode with all pairs cleared
      win_en_reg <= !CWPR_RST_MODE[CWPR_BIT_LINEAR];
      win_y_reg  <= CWPR_RST_WORD[12:0];
      win_w_reg  <= CWPR_RST_WORD[13:0];
      win_h_reg  <= CWPR_RST_WORD[13:0];
      lin_reg    <= CWPR_RST_MODE[CWPR_BIT_LINEAR];
      depth_reg  <= CWPR_BPP8;
      wide_reg   <= 1'b0;
    end else begin
      // Linear mode blanks the window outputs
      win_en_reg <= !lin_nx;
      win_y_reg  <= blk_coord(lin_nx, topy_next);
      win_w_reg  <= blk_size(lin_nx, wid_next);
      win_h_reg  <= blk_size(lin_nx, hgt_next);
      lin_reg    <= lin_nx;
      depth_reg  <= bpp_of(dep_hi_nx, dep_lo_nx);
      wide_reg   <= lin_nx & dep_lo_nx;
    end
  end

  // Position outputs: block coordinates or linear byte addresses
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      // Reset state is block mode with all positions cleared
      wcx_reg  <= CWPR_RST_WORD[12:0];
      wcy_reg  <= CWPR_RST_WORD[12:0];
      wla_reg  <= 32'h0000_0000;       // Block mode
      rcx_reg  <= CWPR_RST_WORD[12:0];
      rcy_reg  <= CWPR_RST_WORD[12:0];
      rla_reg  <= 32'h0000_0000;       // Block mode
      txtx_reg <= CWPR_RST_WORD[12:0];
    end else begin
      wcx_reg  <= blk_coord(lin_nx, gwx_next);
      wcy_reg  <= blk_coord(lin_nx, gwy_next);
      wla_reg  <= lin_addr(lin_nx, gwy_next, gwx_next);
      rcx_reg  <= blk_coord(lin_nx, grx_next);
      rcy_reg  <= blk_coord(lin_nx, gry_next);
      rla_reg  <= lin_addr(lin_nx, gry_next, grx_next);
      txtx_reg <= txt_next[12:0];
    end
  end

  // Output ports driven straight from the flops
  assign win_enable  = win_en_reg;
  assign win_top_y   = win_y_reg;
  assign win_width   = win_w_reg;
  assign win_height  = win_h_reg;
  assign linear_mode = lin_reg;
  assign pixel_depth = depth_reg;
  assign mem_wide    = wide_reg;
  assign wr_coord_x  = wcx_reg;
  assign wr_coord_y  = wcy_reg;
  assign wr_lin_addr = wla_reg;
  assign rd_coord_x  = rcx_reg;
  assign rd_coord_y  = rcy_reg;
  assign rd_lin_addr = rla_reg;
  assign text_x      = txtx_reg;
endmodule : cwpr_regs
`default_nettype wire

// file: rtl/cwpr_pkg.sv
`default_nettype none
package cwpr_pkg;
  // Byte offsets of the register group
  localparam logic [7:0] CWPR_OFF_TOPY_LO = 8'h58; // Window top Y, low byte
  localparam logic [7:0] CWPR_OFF_TOPY_HI = 8'h59; // Window top Y, high byte
  localparam logic [7:0] CWPR_OFF_WID_LO  = 8'h5A; // Window width, low byte
  localparam logic [7:0] CWPR_OFF_WID_HI  = 8'h5B; // Window width, high byte
  localparam logic [7:0] CWPR_OFF_HGT_LO  = 8'h5C; // Window height, low byte
  localparam logic [7:0] CWPR_OFF_HGT_HI  = 8'h5D; // Window height, high byte
  localparam logic [7:0] CWPR_OFF_MODE    = 8'h5E; // Canvas depth and mode
  localparam logic [7:0] CWPR_OFF_GPX_LO  = 8'h5F; // Graphic position X low
  localparam logic [7:0] CWPR_OFF_GPX_HI  = 8'h60; // Graphic position X high
  localparam logic [7:0] CWPR_OFF_GPY_LO  = 8'h61; // Graphic position Y low
  localparam logic [7:0] CWPR_OFF_GPY_HI  = 8'h62; // Graphic position Y high
  localparam logic [7:0] CWPR_OFF_TXT_LO  = 8'h63; // Text position X low
  localparam logic [7:0] CWPR_OFF_TXT_HI  = 8'h64; // Text position X high

  // Field layout of the depth and mode register
  localparam int CWPR_BIT_RDSEL  = 3; // Readback select
  localparam int CWPR_BIT_LINEAR = 2; // Addressing mode
  localparam int CWPR_BIT_DEPTH1 = 1; // Depth, upper bit
  localparam int CWPR_BIT_DEPTH0 = 0; // Depth, lower bit

  // Masks of implemented bits in each 16-bit register pair
  localparam logic [15:0] CWPR_MASK_COORD = 16'h1FFF; // 13-bit coordinate
  localparam logic [15:0] CWPR_MASK_SIZE  = 16'h3FFF; // 14-bit size
  localparam logic [15:0] CWPR_MASK_POS   = 16'hFFFF; // Full position
  localparam logic [7:0]  CWPR_MASK_MODE  = 8'h0F;    // Mode bits 3..0

  // Reset values
  localparam logic [15:0] CWPR_RST_WORD = 16'h0000; // All pairs
  localparam logic [7:0]  CWPR_RST_MODE = 8'h00;    // Mode register

  // Canvas colour depth in block mode
  typedef enum logic [1:0] {
    CWPR_BPP8,
    CWPR_BPP16,
    CWPR_BPP24
  } cwpr_bpp_t;
endpackage : cwpr_pkg
`default_nettype wire

// file: tb/cwpr_regs_chk.sv
`timescale 1ns/100ps
`default_nettype none
// Watches the register block from its ports only
module cwpr_regs_chk (
  input wire logic                clk_sys,
  input wire logic                rst_n,
  input wire logic [7:0]          addr,
  input wire logic [7:0]          wdata,
  input wire logic                wr_stb,
  input wire logic                rd_stb,
  input wire logic [7:0]          rdata,
  input wire logic                eng_text_load,
  input wire logic [12:0]         eng_text_x,
  input wire logic                win_enable,
  input wire logic [12:0]         win_top_y,
  input wire logic [13:0]         win_width,
  input wire logic [13:0]         win_height,
  input wire logic                linear_mode,
  input wire cwpr_pkg::cwpr_bpp_t pixel_depth,
  input wire logic                mem_wide,
  input wire logic [12:0]         wr_coord_x,
  input wire logic [31:0]         wr_lin_addr,
  input wire logic [12:0]         text_x
);
  import cwpr_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  chk_rdata_idle: assert property (!rd_stb |=> rdata == 8'h00)
    else $error("read data not idle");
  chk_window_off: assert property (linear_mode |-> !win_enable &&
    win_top_y == 13'h0 && win_width == 14'h0 && win_height == 14'h0)
    else $error("window in force in linear mode");
  chk_mode_set: assert property (wr_stb && addr == 8'h5E |=>
    linear_mode == $past(wdata[2])) else $error("mode bit not taken");
  chk_wide_set: assert property (wr_stb && addr == 8'h5E |=>
    mem_wide == ($past(wdata[2]) && $past(wdata[0])))
    else $error("transfer width wrong");
  chk_depth_set: assert property (wr_stb && addr == 8'h5E && !wdata[2]
    |=> pixel_depth == ($past(wdata[1]) ? CWPR_BPP24 :
    $past(wdata[0]) ? CWPR_BPP16 : CWPR_BPP8)) else $error("depth wrong");
  chk_addr_split: assert property (linear_mode ? wr_coord_x == 13'h0
    : wr_lin_addr == 32'h0) else $error("address form wrong");
  chk_topy_low: assert property (wr_stb && addr == 8'h58 |=>
    linear_mode || win_top_y[7:0] == $past(wdata))
    else $error("top Y low byte lost");
  chk_text_load: assert property (eng_text_load && !(wr_stb &&
    (addr == 8'h63 || addr == 8'h64)) |=> text_x == $past(eng_text_x))
    else $error("text position load lost");
endmodule : cwpr_regs_chk
bind cwpr_regs cwpr_regs_chk chk_u (.clk_sys, .rst_n, .addr, .wdata,
  .wr_stb, .rd_stb, .rdata, .eng_text_load, .eng_text_x, .win_enable,
  .win_top_y, .win_width, .win_height, .linear_mode, .pixel_depth,
  .mem_wide, .wr_coord_x, .wr_lin_addr, .text_x);
`default_nettype wire

// file: tb/cwpr_host.sv
`timescale 1ns/100ps
`default_nettype none
// Host model: one-cycle strobes, read data taken the cycle after
module cwpr_host (
  input  wire logic       clk_sys, // Core clock
  output logic      [7:0] addr,    // Register address
  output logic      [7:0] wdata,   // Write data
  output logic            wr_stb,  // Write strobe
  output logic            rd_stb,  // Read strobe
  input  wire logic [7:0] rdata    // Read data
);
  // Idle bus from time zero
  initial begin
    addr = 8'h00;
    wdata = 8'h00;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge clk_sys);
    wr_stb <= 1'b0;
  endtask : wr
  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk_sys);
    rd_stb <= 1'b0;
    @(posedge clk_sys);
    d = rdata;
  endtask : rd
endmodule : cwpr_host
`default_nettype wire

// file: tb/cwpr_regs_test.sv
`timescale 1ns/100ps
`default_nettype none
// Register bench: host accesses, engine loads, decoded outputs
module cwpr_regs_test;
  import cwpr_pkg::*;
  logic        clk_sys, rst_n;                   // Clock and reset
  wire  [7:0]  addr, wdata, rdata;               // Bus values
  wire         wr_stb, rd_stb;                   // Bus strobes
  logic        eng_wpos_load, eng_rpos_load, eng_text_load; // Loads
  logic [15:0] eng_wpos_x, eng_wpos_y, eng_rpos_x, eng_rpos_y;
  logic [12:0] eng_text_x, win_top_y, wr_coord_x, text_x; // Coordinates
  logic [12:0] wr_coord_y, rd_coord_x, rd_coord_y; // More coordinates
  logic        win_enable, linear_mode, mem_wide; // Mode decodes
  logic [13:0] win_width, win_height;            // Window size
  logic [31:0] wr_lin_addr, rd_lin_addr;         // Linear addresses
  cwpr_bpp_t   pixel_depth;                      // Colour depth
  logic [7:0]  rv;                               // Last read value
  int          failures, n_checks;               // Tallies
  // Address, write value, expected readback
  logic [23:0] tbl [9] = '{24'h58FFFF, 24'h59E000, 24'h5A0000, 24'h5BD010,
    24'h5C0000, 24'h5DC505, 24'h63FFFF, 24'h64FF1F, 24'h65FF00};
  cwpr_host host_u (.clk_sys, .addr, .wdata, .wr_stb, .rd_stb, .rdata);
  cwpr_regs dut_u (.clk_sys, .rst_n, .addr, .wdata, .wr_stb, .rd_stb,
    .rdata, .eng_wpos_load, .eng_wpos_x, .eng_wpos_y, .eng_rpos_load,
    .eng_rpos_x, .eng_rpos_y, .eng_text_load, .eng_text_x, .win_enable,
    .win_top_y, .win_width, .win_height, .linear_mode, .pixel_depth,
    .mem_wide, .wr_coord_x, .wr_coord_y, .wr_lin_addr, .rd_coord_x,
    .rd_coord_y, .rd_lin_addr, .text_x);
  // 40 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  // Compares and counts; prints on mismatch
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask : check
  // Reads one register and compares it
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    host_u.rd(a, rv);
    check({24'h0, rv}, {24'h0, e});
  endtask : rdchk
  // Prints tallies and verdict
  task automatic finish_test();
    $display("checks=%0d failures=%0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : finish_test
  // Cuts a hang short
  initial begin
    repeat (4000) @(posedge clk_sys);
    failures++;
    finish_test();
  end
  // Main sequence
  initial begin
    {rst_n, eng_wpos_load, eng_rpos_load, eng_text_load} = 4'h0;
    {eng_wpos_x, eng_wpos_y, eng_rpos_x, eng_rpos_y} = 64'h0;
    eng_text_x = 13'h0000;
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'b1;
    for (int a = 8'h58; a <= 8'h64; a++) rdchk(8'(a), 8'h00);
    check(win_enable, 1'b1);
    foreach (tbl[i]) begin
      host_u.wr(tbl[i][23:16], tbl[i][15:8]);
      rdchk(tbl[i][23:16], tbl[i][7:0]);
    end
    check(win_top_y, 13'h00FF);
    check(win_width, 14'h1000);
    check(win_height, 14'h0500);
    check(text_x, 13'h1FFF);
    host_u.wr(8'h5E, 8'hFF);
    rdchk(8'h5E, 8'h0F);
    for (int d = 0; d < 8; d++) begin
      host_u.wr(8'h5E, 8'(d));
      @(negedge clk_sys);
      check(linear_mode, d[2]);
      if (d < 4) begin
        check(pixel_depth, d[1] ? CWPR_BPP24 : cwpr_bpp_t'(d));
      end else begin
        check({win_enable, win_width}, 15'h0000);
        check(mem_wide, d[0]);
      end
    end
    host_u.wr(8'h5E, 8'h00);
    @(posedge clk_sys);
    {eng_wpos_load, eng_rpos_load, eng_text_load} <= 3'b111;
    {eng_wpos_x, eng_wpos_y} <= 32'h1FFF_0003;
    {eng_rpos_x, eng_rpos_y} <= 32'h0ABC_0DEF;
    eng_text_x <= 13'h0155;
    @(posedge clk_sys);
    {eng_wpos_load, eng_rpos_load, eng_text_load} <= 3'b000;
    @(negedge clk_sys);
    check({wr_coord_x, text_x}, {13'h1FFF, 13'h0155});
    check(wr_coord_y, 13'h0003);
    check({rd_coord_x, rd_coord_y}, {13'h0ABC, 13'h0DEF});
    rdchk(8'h60, 8'h1F);
    host_u.wr(8'h5E, 8'h08);
    rdchk(8'h5F, 8'hBC);
    rdchk(8'h62, 8'h0D);
    host_u.wr(8'h5E, 8'h04);
    foreach (tbl[i]) if (i < 4) host_u.wr(8'h5F + 8'(i), 8'h12 + 8'(i * 34));
    @(negedge clk_sys);
    check(wr_lin_addr, 32'h78563412);
    check(rd_lin_addr, 32'h78563412);
    check({wr_coord_y, rd_coord_x}, 26'h0000000);
    rdchk(8'h62, 8'h78);
    host_u.wr(8'h5E, 8'h00);
    rdchk(8'h62, 8'h18);
    check(wr_coord_x, 13'h1412);
    check({rd_coord_x, rd_coord_y}, {13'h1412, 13'h1856});
    finish_test();
  end
endmodule : cwpr_regs_test
`default_nettype wire
